// ### design/adps_pkg.sv
// Purpose: Shared constants and types for the analog/digital pin selector.
// Assumes: One 8-bit selection register in a 32-bit word, four-bit count field.
// Notes:   Register offset lies inside the slave's own 4 KB window.
package adps_pkg;

   // Pin counts
   localparam int unsigned   ADPS_PIN_COUNT          = 15;
   localparam int unsigned   ADPS_PORT2_PINS         = 8;

   // Register layout
   localparam logic [11:0]   ADPS_SEL_OFFSET         = 12'h000;
   localparam int unsigned   ADPS_REG_W              = 8;
   localparam int unsigned   ADPS_FIELD_LSB          = 0;
   localparam int unsigned   ADPS_FIELD_MSB          = 3;
   localparam logic [3:0]    ADPS_SEL_RESET          = 4'h0;
   localparam logic [3:0]    ADPS_FIELD_ALL_ANALOG   = 4'h0;
   localparam logic [3:0]    ADPS_FIELD_ALL_DIGITAL  = 4'h1;

   // Pins shared with the D/A converter outputs
   localparam int unsigned   ADPS_DAC0_PIN           = 2;
   localparam int unsigned   ADPS_DAC1_PIN           = 3;

   // AHB-Lite encodings
   localparam logic [1:0]    ADPS_HTRANS_IDLE        = 2'h0;
   localparam logic [1:0]    ADPS_HTRANS_NONSEQ      = 2'h2;
   localparam logic          ADPS_HRESP_OKAY         = 1'b0;

   typedef logic [14:0] adps_pin_vec_t;
   typedef logic [3:0]  adps_field_t;

   // Pin side reset images: every pin analog, DAC paths allowed, pads released
   localparam adps_pin_vec_t ADPS_ANALOG_RESET   = 15'h7fff;
   localparam logic [1:0]    ADPS_DAC_EN_RESET   = 2'h3;
   localparam adps_pin_vec_t ADPS_OE_N_RESET     = 15'h7fff;

endpackage

// ### design/adps_sel_if.sv
// Purpose: Carries the selection field to the decoder and the pin mask back.
// Assumes: Decoder is purely combinational.
// Notes:   ctrl side owns the field, dec side owns the mask.
`timescale 1ns/1ns
`default_nettype none
interface adps_sel_if;
   import adps_pkg::*;

   adps_field_t   field;
   adps_pin_vec_t analog_mask;

   modport ctrl (output field, input analog_mask);
   modport dec  (input field, output analog_mask);
endinterface
`default_nettype wire

// ### design/adps_decode.sv
// Purpose: Turns the four-bit count field into a per-pin analog mask.
// Assumes: Mask bit i set means converter input i is analog.
// Notes:   All sixteen codes are meaningful; none is illegal.
`timescale 1ns/1ns
`default_nettype none
module adps_decode
   import adps_pkg::*;
(
   adps_sel_if.dec sel
);

   // Code 0 keeps every pin analog, code n keeps inputs 0 to n-2 analog
   function automatic adps_pin_vec_t adps_field_to_mask(input adps_field_t f);
      logic [15:0] ones;
      ones = 16'h0000;
      if (f == ADPS_FIELD_ALL_ANALOG)
      begin
         ones = 16'hffff;
      end
      else
      begin
         ones = (16'h0001 << (f - 4'h1)) - 16'h0001;
      end
      return ones[14:0];
   endfunction

   // Combinational decode
   always_comb
   begin
      sel.analog_mask = adps_field_to_mask(sel.field);
   end

endmodule // adps_decode
`default_nettype wire

// ### design/adps_top.sv
// Purpose: AHB-Lite register and pin steering for shared analog/digital pins.
// Assumes: Single-word transfers, one slave, zero wait states.
// Notes:   Pins 0-7 are port 2 pins 0-7, pins 8-14 are port 15 pins 0-6.
//
// How it works
// [R1] One register picks analog or digital per pin
// [R2] Reset puts every controlled pin into analog
// [R3] Fifteen inputs: port 2 and port 15 pins
// [R4] DAC outputs follow inputs two and three
// [R5] Eight-bit register, field bits 3-0, upper zero
// [R6] Field counts analog inputs; 0 all, 1 none
// [R7] Upper four bits ignore writes, read zero
`timescale 1ns/1ns
`default_nettype none
module adps_top
   import adps_pkg::*;
(
   input  wire logic          CLK_SYS,
   input  wire logic          NRST,
   input  wire logic          HSEL,
   input  wire logic [31:0]   HADDR,
   input  wire logic [1:0]    HTRANS,
   input  wire logic          HWRITE,
   input  wire logic [2:0]    HSIZE,
   input  wire logic          HREADY,
   input  wire logic [31:0]   HWDATA,
   output logic      [31:0]   HRDATA,
   output logic               HREADYOUT,
   output logic               HRESP,
   input  wire logic [14:0]   PIN_IN,
   output logic      [14:0]   PIN_OUT,
   output logic      [14:0]   PIN_OE_N,
   input  wire logic [14:0]   PORT_DOUT,
   input  wire logic [14:0]   PORT_DRIVE,
   output logic      [14:0]   PORT_DIN,
   output logic      [14:0]   ANALOG_SEL,
   output logic      [1:0]    DAC_OUT_EN
);

   // Bus side
   logic             addr_valid;
   logic             addr_hit;
   logic             dp_write_q;
   logic             dp_read_q;
   logic             dp_hit_q;
   logic             wr_en;
   logic [31:0]      rdata_d;
   logic [31:0]      rdata_q;
   adps_field_t      field_q;
   adps_field_t      field_fwd;

   // Pin side
   adps_pin_vec_t    mask;
   adps_pin_vec_t    analog_q;
   logic [1:0]       dac_en_q;
   adps_pin_vec_t    pin_out_q;
   adps_pin_vec_t    pin_oe_n_q;
   adps_pin_vec_t    sync1_q;
   adps_pin_vec_t    sync2_q;
   adps_pin_vec_t    sync3_q;
   adps_pin_vec_t    filt_d;
   adps_pin_vec_t    filt_q;
   adps_pin_vec_t    din_q;

   adps_sel_if       sel_if ();

   // Word image of the register: only the field is held, bits above read zero
   function automatic logic [31:0] adps_reg_word(input adps_field_t f);
      return {28'h0000000, f};
   endfunction

   // Register decode inside the slave's 4 KB window
   function automatic logic adps_addr_hit(input logic [31:0] a);
      return (a[11:2] == ADPS_SEL_OFFSET[11:2]);
   endfunction

   // Address phase is taken when selected, NONSEQ or SEQ (not IDLE or BUSY) and the bus is ready
   assign addr_valid = HSEL & HTRANS[1] & HREADY;
   assign addr_hit   = adps_addr_hit(HADDR);
   assign wr_en      = dp_write_q & dp_hit_q;

   // Data phase bookkeeping
   always_ff @(posedge CLK_SYS)
   begin
      if (!NRST)
      begin
         dp_write_q <= 1'b0;
         dp_read_q  <= 1'b0;
         dp_hit_q   <= 1'b0;
      end
      else
      begin
         dp_write_q <= addr_valid & HWRITE;
         dp_read_q  <= addr_valid & ~HWRITE;
         dp_hit_q   <= addr_valid & addr_hit;
      end
   end

   // Selection field: only bits 3-0 are stored, the rest of the byte is dropped
   always_ff @(posedge CLK_SYS)
   begin
      if (!NRST)
      begin
         field_q <= ADPS_SEL_RESET;                               // [R2]
      end
      else if (wr_en)
      begin
         field_q <= HWDATA[ADPS_FIELD_MSB:ADPS_FIELD_LSB];        // [R1] [R5] [R7]
      end
   end

   // A write finishing now is forwarded so a back-to-back read sees it
   assign field_fwd = wr_en ? HWDATA[ADPS_FIELD_MSB:ADPS_FIELD_LSB] : field_q;

   // Read data prepared at the address phase; unmapped reads give zero
   always_comb
   begin
      rdata_d = 32'h00000000;
      if (addr_valid && !HWRITE && addr_hit)
      begin
         rdata_d = adps_reg_word(field_fwd);                      // [R5] [R7]
      end
   end

   // Read data register
   always_ff @(posedge CLK_SYS)
   begin
      if (!NRST)
      begin
         rdata_q <= 32'h00000000;
      end
      else
      begin
         rdata_q <= rdata_d;
      end
   end

   // Zero wait states, always OKAY
   assign HRDATA    = rdata_q;
   assign HREADYOUT = 1'b1;
   assign HRESP     = ADPS_HRESP_OKAY;

   // Count field to per-pin mask
   assign sel_if.field = field_q;
   assign mask         = sel_if.analog_mask;

   adps_decode u_decode
   (
      .sel (sel_if.dec)
   );

   // Analog selects and DAC enables; DAC channels sit on pins 2 and 3
   always_ff @(posedge CLK_SYS)
   begin
      if (!NRST)
      begin
         analog_q <= ADPS_ANALOG_RESET;                           // [R2]
         dac_en_q <= ADPS_DAC_EN_RESET;                           // [R2]
      end
      else
      begin
         analog_q <= mask;                                        // [R1] [R6]
         dac_en_q <= {mask[ADPS_DAC1_PIN], mask[ADPS_DAC0_PIN]};  // [R4]
      end
   end

   // Pad drivers: an analog pin is never driven by the digital port
   always_ff @(posedge CLK_SYS)
   begin
      if (!NRST)
      begin
         pin_out_q  <= 15'h0000;
         pin_oe_n_q <= ADPS_OE_N_RESET;                           // [R2]
      end
      else
      begin
         pin_out_q  <= PORT_DOUT & ~mask;                         // [R3]
         pin_oe_n_q <= ~(PORT_DRIVE & ~mask);                     // [R3]
      end
   end

   // Pad input synchroniser, three stages
   always_ff @(posedge CLK_SYS)
   begin
      if (!NRST)
      begin
         sync1_q <= 15'h0000;
         sync2_q <= 15'h0000;
         sync3_q <= 15'h0000;
      end
      else
      begin
         sync1_q <= PIN_IN;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
      end
   end

   // A level change counts only once stages two and three agree
   assign filt_d = (sync2_q & sync3_q) | (filt_q & (sync2_q ^ sync3_q));

   // Filtered input; analog pins read as zero on the digital side
   always_ff @(posedge CLK_SYS)
   begin
      if (!NRST)
      begin
         filt_q <= 15'h0000;
         din_q  <= 15'h0000;
      end
      else
      begin
         filt_q <= filt_d;
         din_q  <= filt_q & ~analog_q;                            // [R1] [R3]
      end
   end

   // Pin side outputs
   assign ANALOG_SEL = analog_q;
   assign DAC_OUT_EN = dac_en_q;
   assign PIN_OUT    = pin_out_q;
   assign PIN_OE_N   = pin_oe_n_q;
   assign PORT_DIN   = din_q;

   // Reset leaves every pin analog and released, DAC paths enabled
   AST_RESET_ANALOG: assert property (                                        // [R2]
      @(posedge CLK_SYS)
      !NRST |=> (ANALOG_SEL == 15'h7fff) && (PIN_OE_N == 15'h7fff) && (DAC_OUT_EN == 2'h3)
   ) else $error("Reset did not leave all pins analog");

   // A register write lands in the field and reaches the pins two edges later
   AST_WRITE_STEERS: assert property (                                        // [R1]
      @(posedge CLK_SYS) disable iff (!NRST)
      wr_en |=> (field_q == $past(HWDATA[3:0])) ##2 (ANALOG_SEL == $past(mask))
   ) else $error("Written selection did not steer the pins");

   // An analog pin is never driven by the port
   AST_ANALOG_RELEASED: assert property (                                     // [R3]
      @(posedge CLK_SYS) disable iff (!NRST)
      (ANALOG_SEL & ~PIN_OE_N) == 15'h0000
   ) else $error("Analog pin is driven digitally");

   // Analog pins read back zero on the digital input side
   AST_ANALOG_NO_DIN: assert property (                                       // [R3]
      @(posedge CLK_SYS) disable iff (!NRST)
      1'b1 |=> (PORT_DIN & $past(ANALOG_SEL)) == 15'h0000
   ) else $error("Analog pin passes digital input");

   // DAC enables track converter inputs two and three
   AST_DAC_FOLLOWS: assert property (                                         // [R4]
      @(posedge CLK_SYS) disable iff (!NRST)
      DAC_OUT_EN == {ANALOG_SEL[3], ANALOG_SEL[2]}
   ) else $error("DAC enable differs from its shared input");

   // Any read shows zeros above the field
   AST_UPPER_ZERO: assert property (                                          // [R5]
      @(posedge CLK_SYS) disable iff (!NRST)
      dp_read_q |-> (HRDATA[31:4] == 28'h0000000)
   ) else $error("Bits above the field read nonzero");

   // Code 0 keeps all analog, otherwise n-1 analog inputs
   AST_COUNT_MAP: assert property (                                           // [R6]
      @(posedge CLK_SYS) disable iff (!NRST)
      ($past(field_q) == ADPS_FIELD_ALL_ANALOG) ? (ANALOG_SEL == 15'h7fff)
         : ($countones(ANALOG_SEL) == int'($past(field_q)) - 1)
   ) else $error("Analog pin count does not match the field");

   // Analog pins are always the lowest-numbered ones
   AST_LOW_PINS_FIRST: assert property (                                      // [R6]
      @(posedge CLK_SYS) disable iff (!NRST)
      ((ANALOG_SEL + 15'h0001) & ANALOG_SEL) == 15'h0000
   ) else $error("Analog pins are not contiguous from input zero");

   // Readback holds only the stored field whatever was written above it
   AST_READBACK_FIELD: assert property (                                      // [R7]
      @(posedge CLK_SYS) disable iff (!NRST)
      (dp_read_q && dp_hit_q) |-> (HRDATA == {28'h0000000, field_q})
   ) else $error("Readback differs from the stored field");

   // Reset clears the field, the read data and the digital pad paths
   AST_RESET_FIELD: assert property (                                         // [R2]
      @(posedge CLK_SYS)
      !NRST |=> (field_q == ADPS_SEL_RESET) && (HRDATA == 32'h00000000) && (PIN_OUT == 15'h0000) && (PORT_DIN == 15'h0000)
   ) else $error("Reset did not clear field and digital paths");

   // The field changes only through a register write
   AST_FIELD_HOLDS: assert property (                                         // [R1]
      @(posedge CLK_SYS) disable iff (!NRST)
      !wr_en |=> $stable(field_q)
   ) else $error("Selection field changed without a write");

   // Port output data never reaches an analog pin
   AST_PIN_OUT_MASKED: assert property (                                      // [R3]
      @(posedge CLK_SYS) disable iff (!NRST)
      (PIN_OUT & ANALOG_SEL) == 15'h0000
   ) else $error("Port data appears on an analog pin");

   // A digital pin is driven exactly when the port asked for it
   AST_DRIVE_FOLLOWS_PORT: assert property (                                  // [R3]
      @(posedge CLK_SYS) disable iff (!NRST)
      1'b1 |=> (PIN_OE_N == ~($past(PORT_DRIVE) & ~ANALOG_SEL))
   ) else $error("Pad enable does not follow the port request");

endmodule // adps_top
`default_nettype wire

// ### verif/adps_tb.sv
// Purpose: Self-checking bench for the analog/digital pin selector.
// Assumes: Zero-wait AHB-Lite slave, register at byte address 0.
// Notes:   Bench drives all inputs except HREADY, which loops back from HREADYOUT; HSIZE is tied to word size.
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import adps_pkg::*;

   logic          clk_sys;
   logic          nrst;
   logic          hsel;
   logic [31:0]   haddr;
   logic [1:0]    htrans;
   logic          hwrite;
   logic [2:0]    hsize;
   wire  logic    hready;
   logic [31:0]   hwdata;
   wire  logic [31:0] hrdata;
   wire  logic    hresp;
   logic [14:0]   pin_in;
   wire  logic [14:0] pin_out;
   wire  logic [14:0] pin_oe_n;
   logic [14:0]   port_dout;
   logic [14:0]   port_drive;
   wire  logic [14:0] port_din;
   wire  logic [14:0] analog_sel;
   wire  logic [1:0]  dac_out_en;
   int            errors;
   int            n_checks;
   logic [31:0]   rd;

   adps_top dut (.CLK_SYS(clk_sys), .NRST(nrst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwrite), .HSIZE(hsize), .HREADY(hready), .HWDATA(hwdata), .HRDATA(hrdata),
      .HREADYOUT(hready), .HRESP(hresp), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE_N(pin_oe_n),
      .PORT_DOUT(port_dout), .PORT_DRIVE(port_drive), .PORT_DIN(port_din),
      .ANALOG_SEL(analog_sel), .DAC_OUT_EN(dac_out_en));

   // Free-running 50 MHz clock
   initial
   begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   task automatic complete_run();
      if (errors == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Waits for hready at a rising edge, bounded
   task automatic wait_ready();
      int k;
      k = 0;
      do
      begin
         @(posedge clk_sys);
         k++;
      end
      while (hready !== 1'b1 && k < 50);
      if (k >= 50)
         chk(32'h0, 32'h1);
   endtask

   // One AHB-Lite single word transfer; read data taken at the data phase edge
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
      hsel   <= 1'b1;
      htrans <= ADPS_HTRANS_NONSEQ;
      hwrite <= wr;
      haddr  <= a;
      wait_ready();
      hsel   <= 1'b0;
      htrans <= ADPS_HTRANS_IDLE;
      hwdata <= wr ? d : 32'h0;
      wait_ready();
      q = hrdata;
      chk({31'h0, hresp}, {31'h0, ADPS_HRESP_OKAY});
   endtask

   // Expected analog mask for a field value
   function automatic logic [14:0] exp_mask(input logic [3:0] n);
      if (n == 4'h0)
         return 15'h7fff;
      if (n == 4'h1)
         return 15'h0000;
      return 15'((32'h1 << (n - 1)) - 1);
   endfunction

   // Writes the field, then lets the pin outputs settle
   task automatic set_field(input logic [31:0] v);
      ahb(1'b1, 32'h0, v, rd);
      repeat (6) @(posedge clk_sys);
   endtask

   task automatic test_reset_state();
      ahb(1'b0, 32'h0, 32'h0, rd);
      chk(rd, 32'h0);
      chk({17'h0, analog_sel}, 32'h7fff);
      chk({30'h0, dac_out_en}, 32'h3);
      chk({17'h0, pin_oe_n}, 32'h7fff);
   endtask

   // Every code, upper bits written as ones
   task automatic test_all_codes();
      logic [14:0] m;
      for (int n = 0; n < 16; n++)
      begin
         m = exp_mask(4'(n));
         set_field({28'hfffffff, 4'(n)});
         chk({17'h0, analog_sel}, {17'h0, m});
         chk({30'h0, dac_out_en}, {30'h0, m[3:2]});
         ahb(1'b0, 32'h0, 32'h0, rd);
         chk(rd, {28'h0, 4'(n)});
      end
   endtask

   task automatic test_unmapped();
      set_field(32'h9);
      ahb(1'b1, 32'h4, 32'hffffffff, rd);
      ahb(1'b0, 32'h4, 32'h0, rd);
      chk(rd, 32'h0);
      ahb(1'b0, 32'h0, 32'h0, rd);
      chk(rd, 32'h9);
   endtask

   // Digital pins pass port data, analog pins are blocked
   task automatic test_pins();
      port_dout  <= 15'h2aaa;
      port_drive <= 15'h5555;
      pin_in     <= 15'h3c3c;
      set_field(32'h5);
      chk({17'h0, pin_out}, 32'h2aa0);
      chk({17'h0, pin_oe_n}, 32'h2aaf);
      chk({17'h0, port_din}, 32'h3c30);
      set_field(32'h0);
      chk({17'h0, pin_out | port_din}, 32'h0);
      chk({17'h0, pin_oe_n}, 32'h7fff);
   endtask

   // Reset in mid-run returns everything to analog
   task automatic test_mid_reset();
      set_field(32'h3);
      @(posedge clk_sys);
      nrst <= 1'b0;
      repeat (3) @(posedge clk_sys);
      nrst <= 1'b1;
      @(posedge clk_sys);
      test_reset_state();
   endtask

   // Watchdog against a hung bus
   initial
   begin
      #200000;
      errors++;
      complete_run();
   end

   // Main sequence
   initial
   begin
      errors     = 0;
      n_checks   = 0;
      nrst       = 1'b0;
      hsel       = 1'b0;
      haddr      = 32'h0;
      htrans     = ADPS_HTRANS_IDLE;
      hwrite     = 1'b0;
      hsize      = 3'h2;
      hwdata     = 32'h0;
      pin_in     = 15'h0;
      port_dout  = 15'h0;
      port_drive = 15'h0;
      repeat (5) @(posedge clk_sys);
      nrst <= 1'b1;
      @(posedge clk_sys);
      test_reset_state();
      test_all_codes();
      test_unmapped();
      test_pins();
      test_mid_reset();
      complete_run();
   end
endmodule // testbench
`default_nettype wire
